// File: src/reg_bank.sv
// byte-wide register bank showing the shared access conventions
// How it works
// - most registers are one byte at one byte address.
// - the event counter spans two consecutive bytes, low byte first.
// - reserved bits and bytes have no function.
// - write-one-to-clear status reads state, clears on 1, keeps on 0.
// - write-one-to-act command bits read zero, a 1 starts the action.
// - no retention; reset restores every register.
`timescale 1ns/1ps
module reg_bank
  import reg_conv_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register master port, same clock
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // block events and state
  input wire logic [3:0] event_in,
  input wire logic [3:0] state_in,
  // steering outputs
  output logic [5:0] ctrl_out,
  output logic [7:0] cfg_out,
  output logic [3:0] irq_pending
);
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DONE = 2'b10} rd_state_t;
  rd_state_t rd_state_q;
  rd_state_t rd_state_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] status_q;
  logic [7:0] event_sync1_q;
  logic [7:0] event_sync2_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [7:0] cnt_hi_snap_q;
  logic sel_ctrl;
  logic sel_cfg;
  logic sel_irq;
  logic sel_cmd;
  logic sel_cnt_lo;
  logic sel_cnt_hi;
  logic [7:0] cmd_act;

  reg_acc_if #(.W(8)) ctrl_acc ();
  reg_acc_if #(.W(8)) cfg_acc ();
  reg_acc_if #(.W(8)) irq_acc ();
  reg_acc_if #(.W(8)) cmd_acc ();

  assign sel_ctrl = (reg_addr == OFS_CTRL);
  assign sel_cfg = (reg_addr == OFS_CFG);
  assign sel_irq = (reg_addr == OFS_IRQ_STAT);
  assign sel_cmd = (reg_addr == OFS_CMD);
  assign sel_cnt_lo = (reg_addr == OFS_CNT_LO);
  assign sel_cnt_hi = (reg_addr == OFS_CNT_HI);

  // writes to reserved offsets select nothing
  assign ctrl_acc.wr = reg_wr && sel_ctrl;
  assign ctrl_acc.wdata = reg_wdata;
  assign ctrl_acc.hw_set = 8'h00;
  assign cfg_acc.wr = reg_wr && sel_cfg;
  assign cfg_acc.wdata = reg_wdata;
  assign cfg_acc.hw_set = 8'h00;
  assign irq_acc.wr = reg_wr && sel_irq;
  assign irq_acc.wdata = reg_wdata;
  assign cmd_acc.wr = reg_wr && sel_cmd;
  assign cmd_acc.wdata = reg_wdata;
  assign cmd_acc.hw_set = 8'h00;

  // event inputs come from outside, so synchronise before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      event_sync1_q <= 8'h00;
      event_sync2_q <= 8'h00;
    end else if (clk_en) begin
      event_sync1_q <= {state_in, event_in};
      event_sync2_q <= event_sync1_q;
    end
  end

  // state bits are levels, so a one-cycle skew between bits is harmless
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= 8'h00;
    end else if (clk_en) begin
      status_q <= {4'h0, event_sync2_q[7:4]} & STATUS_RO_MASK;
    end
  end
  assign irq_acc.hw_set = {4'h0, event_sync2_q[3:0]};

  // one field module per writable byte; the command byte keeps no state
  reg_field #(
    .RW_MASK(CTRL_RW_MASK),
    .W1C_MASK(8'h00),
    .W1A_MASK(8'h00),
    .RST_VAL(CTRL_RST)
  ) u_ctrl (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .acc(ctrl_acc.field)
  );

  reg_field #(
    .RW_MASK(CFG_RW_MASK),
    .W1C_MASK(8'h00),
    .W1A_MASK(8'h00),
    .RST_VAL(CFG_RST)
  ) u_cfg (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .acc(cfg_acc.field)
  );

  reg_field #(
    .RW_MASK(8'h00),
    .W1C_MASK(IRQ_W1C_MASK),
    .W1A_MASK(8'h00),
    .RST_VAL(8'h00)
  ) u_irq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .acc(irq_acc.field)
  );

  reg_field #(
    .RW_MASK(8'h00),
    .W1C_MASK(8'h00),
    .W1A_MASK(CMD_W1A_MASK),
    .RST_VAL(8'h00)
  ) u_cmd (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .acc(cmd_acc.field)
  );

  assign cmd_act = cmd_acc.act;

  // the CMD_CLR_CNT pulse clears the counter; counting gated by control
  assign cnt_d = cmd_act[CMD_CLR_CNT] ? CNT_W'(CNT_RST) :
                 (ctrl_acc.rdata[CTRL_CNT_EN] && (|event_sync2_q[3:0])) ?
                 cnt_q + CNT_W'(1) : cnt_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= CNT_W'(CNT_RST);
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  // low-byte read freezes the high byte for a coherent pair
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_hi_snap_q <= 8'h00;
    end else if (clk_en && ((reg_rd && sel_cnt_lo) || cmd_act[CMD_SNAP])) begin
      cnt_hi_snap_q <= cnt_q[15:8];
    end
  end

  // unmapped and reserved bytes read zero
  always_comb begin
    rdata_d = 8'h00;
    if (sel_ctrl) begin
      rdata_d = ctrl_acc.rdata;
    end else if (sel_cfg) begin
      rdata_d = cfg_acc.rdata;
    end else if (reg_addr == OFS_STATUS) begin
      rdata_d = status_q;
    end else if (sel_irq) begin
      rdata_d = irq_acc.rdata;
    end else if (sel_cmd) begin
      rdata_d = 8'h00;
    end else if (sel_cnt_lo) begin
      rdata_d = cnt_q[7:0];
    end else if (sel_cnt_hi) begin
      rdata_d = cnt_hi_snap_q;
    end
  end

  always_comb begin
    case (rd_state_q)
      RD_IDLE: rd_state_d = reg_rd ? RD_DONE : RD_IDLE;
      RD_DONE: rd_state_d = reg_rd ? RD_DONE : RD_IDLE;
      default: rd_state_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_state_q <= RD_IDLE;
    end else if (clk_en) begin
      rd_state_q <= rd_state_d;
    end
  end

  // read data returned one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = (rd_state_q == RD_DONE);
  assign ctrl_out = ctrl_acc.rdata[5:0];
  assign cfg_out = cfg_acc.rdata;
  assign irq_pending = irq_acc.rdata[3:0];
endmodule : reg_bank

// File: inc/reg_conv_pkg.sv
// package with register bank layout, access masks and reset values
package reg_conv_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  // byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_CNT_LO = 4'h5;
  localparam logic [3:0] OFS_CNT_HI = 4'h6;
  localparam logic [3:0] OFS_RSVD = 4'h7;
  // access-type field masks per register
  localparam logic [7:0] CTRL_RW_MASK = 8'h3F;
  localparam logic [7:0] CFG_RW_MASK = 8'hFF;
  localparam logic [7:0] STATUS_RO_MASK = 8'h0F;
  localparam logic [7:0] IRQ_W1C_MASK = 8'h0F;
  localparam logic [7:0] CMD_W1A_MASK = 8'h03;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // command bit positions
  localparam int CMD_CLR_CNT = 0;
  localparam int CMD_SNAP = 1;
  // control bit positions
  localparam int CTRL_CNT_EN = 0;
endpackage : reg_conv_pkg

// File: inc/reg_acc_if.sv
// interface carrying one register field access between bank and field module
`timescale 1ns/1ps
interface reg_acc_if #(parameter int W = 8);
  logic wr;
  logic [W-1:0] wdata;
  logic [W-1:0] hw_set;
  logic [W-1:0] rdata;
  logic [W-1:0] act;
  modport bank (output wr, output wdata, output hw_set, input rdata, input act);
  modport field (input wr, input wdata, input hw_set, output rdata, output act);
endinterface : reg_acc_if

// File: src/reg_field.sv
// one byte register with per-bit access type
`timescale 1ns/1ps
module reg_field #(
  parameter logic [7:0] RW_MASK = 8'h00,
  parameter logic [7:0] W1C_MASK = 8'h00,
  parameter logic [7:0] W1A_MASK = 8'h00,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // access
  reg_acc_if.field acc
);
  logic [7:0] val_q;
  logic [7:0] val_d;
  logic [7:0] w1c_clr;
  // set wins over a same-cycle clear
  assign w1c_clr = acc.wr ? (acc.wdata & W1C_MASK) : 8'h00;
  // only read-write bits take write data
  assign val_d = (acc.wr ? ((val_q & ~RW_MASK) | (acc.wdata & RW_MASK)) : val_q)
                 & ~w1c_clr | (acc.hw_set & W1C_MASK);
  always_ff @(posedge mclk) begin
    // contents come back at reset value
    if (sys_rst) begin
      val_q <= RST_VAL;
    end else if (clk_en) begin
      val_q <= val_d & (RW_MASK | W1C_MASK);
    end
  end
  // bits outside any type read zero
  assign acc.rdata = val_q & (RW_MASK | W1C_MASK);
  // one-cycle action pulse per written one
  assign acc.act = (acc.wr && clk_en) ? (acc.wdata & W1A_MASK) : 8'h00;
endmodule : reg_field

// File: verif/reg_bank_assertions.sv
// port checker for the register bank
`timescale 1ns/1ps
module reg_bank_assertions
  import reg_conv_pkg::*;
#(parameter int CNT_W = 16) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // master port and block pins
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [3:0] event_in,
  input wire logic [3:0] state_in,
  input wire logic [5:0] ctrl_out,
  input wire logic [7:0] cfg_out,
  input wire logic [3:0] irq_pending
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire rd_go = reg_rd && clk_en;
  wire wr_go = reg_wr && clk_en;
  a_read_answers: assert property (rd_go |=> reg_rvalid)
    else $error("no read answer");
  a_rdata_holds: assert property (!rd_go |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ctrl_takes: assert property (wr_go && reg_addr == OFS_CTRL |=> ctrl_out == $past(reg_wdata[5:0]))
    else $error("ctrl write lost");
  a_cfg_takes: assert property (wr_go && reg_addr == OFS_CFG |=> cfg_out == $past(reg_wdata))
    else $error("cfg write lost");
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> {ctrl_out, cfg_out, irq_pending} == 18'h0)
    else $error("state kept over reset");
  a_irq_keeps: assert property (!(wr_go && reg_addr == OFS_IRQ_STAT) |=> ($past(irq_pending) & ~irq_pending) == 4'h0)
    else $error("irq cleared without write");
  a_rsvd_zero: assert property (rd_go && reg_addr >= OFS_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  a_cmd_zero: assert property (rd_go && reg_addr == OFS_CMD |=> reg_rdata == 8'h00)
    else $error("command byte not zero");
endmodule : reg_bank_assertions
bind reg_bank reg_bank_assertions #(.CNT_W(CNT_W)) chk (.*);

// File: verif/reg_master.sv
// register master model on the bank's access port
`timescale 1ns/1ps
module reg_master (
  // clock
  input wire logic mclk,
  // access port
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0;
  // called just after an edge; the request is taken at the next edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    q = 8'h00;
    if (w && a >= 4'h7) return;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge mclk);
    // released strobes drop to zero, address and data show the inverse so a stale sample stands out
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    // read answer stands through the cycle after the taken edge
    @(posedge mclk);
    q = (w || reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    #1;
  endtask : acc
  task automatic rmw(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    acc(1'b1, a, (q & ~m) | (v & m), q);
  endtask : rmw
endmodule : reg_master

// File: verif/reg_bank_bench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module reg_bank_bench;
  import reg_conv_pkg::*;
  logic mclk = 0, sys_rst = 1, clk_en = 1, reg_wr, reg_rd, reg_rvalid;
  logic [3:0] event_in = 4'h0, state_in = 4'h9, reg_addr, irq_pending;
  logic [7:0] reg_wdata, reg_rdata, cfg_out, q;
  logic [5:0] ctrl_out;
  int n_fail = 0, n_compared = 0;
  always #2 mclk = ~mclk;
  reg_bank dut (.*);
  reg_master mst (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    mst.acc(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    mst.acc(1'b1, a, d, q);
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle
  task automatic t_rw();
    wr(OFS_CTRL, 8'hFF);
    rd(OFS_CTRL, 8'h3F);
    wr(OFS_CFG, 8'hA5);
    rd(OFS_CFG, 8'hA5);
    chk(cfg_out, 8'hA5);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h09);
    for (int a = 7; a < 16; a++) rd(a[3:0], 8'h00);
  endtask : t_rw
  task automatic t_w1c();
    event_in = 4'h5;
    idle(1);
    event_in = 4'h0;
    idle(3);
    rd(OFS_IRQ_STAT, 8'h05);
    wr(OFS_IRQ_STAT, 8'h00);
    rd(OFS_IRQ_STAT, 8'h05);
    wr(OFS_IRQ_STAT, 8'h01);
    rd(OFS_IRQ_STAT, 8'h04);
    chk({4'h0, irq_pending}, 8'h04);
  endtask : t_w1c
  task automatic t_hold();
    clk_en = 0;
    wr(OFS_CFG, 8'h5A);
    clk_en = 1;
    rd(OFS_CFG, 8'hA5);
    chk(cfg_out, 8'hA5);
  endtask : t_hold
  task automatic t_cnt();
    wr(OFS_CMD, 8'h03);
    event_in = 4'h1;
    idle(10);
    event_in = 4'h0;
    idle(4);
    rd(OFS_CNT_LO, 8'h0A);
    rd(OFS_CNT_HI, 8'h00);
    rd(OFS_CMD, 8'h00);
    mst.rmw(OFS_CTRL, 8'h01, 8'h00);
    chk({2'b00, ctrl_out}, 8'h3E);
    event_in = 4'h1;
    idle(5);
    event_in = 4'h0;
    idle(4);
    rd(OFS_CNT_LO, 8'h0A);
  endtask : t_cnt
  task automatic t_rst();
    sys_rst = 1;
    idle(2);
    sys_rst = 0;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_CFG, 8'h00);
    rd(OFS_IRQ_STAT, 8'h00);
  endtask : t_rst
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    idle(2);
    sys_rst = 0;
    t_rst();
    t_rw();
    t_hold();
    t_w1c();
    t_cnt();
    t_rst();
    end_of_test();
  end
  // whole run needs well under 200 cycles
  initial begin
    #4000;
    n_fail++;
    end_of_test();
  end
endmodule : reg_bank_bench
